// *** dv/sdito_chk.sv ***
// Assertion checker bound to the timecode and output modifier top
`timescale 1ns/1ps
module sdito_chk
  import sdito_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Video out and flags
  input wire logic outValid,
  input wire logic outReady,
  input wire sdito_pix_t pixOut,
  input wire logic ltcInsert,
  input wire logic vitcInsert,
  input wire logic audioMute,
  input wire logic nonStandard
);
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [8:0] ctrlSeen;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Last control word written over the bus
  always_ff @(posedge clock) begin
    if (s_axi_awvalid && s_axi_awready) wrAddr <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) begin
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlSeen <= '0;
    end else if (s_axi_bvalid && s_axi_bready && wrAddr == REG_CTRL) begin
      // Lane 0 holds bits 7:0, lane 1 holds bit 8
      if (wrStrb[0]) ctrlSeen[7:0] <= wrData[7:0];
      if (wrStrb[1]) ctrlSeen[8] <= wrData[8];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Bus and stream holds, and no read accepted while one is pending
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_out_hold: assert property (outValid && !outReady |=>
    outValid && $stable(pixOut)) else $error("video sample dropped");
  // Flags follow the control word once the write settles
  chk_ltc_follow: assert property (
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> ltcInsert == ctrlSeen[2])
    else $error("ltc flag wrong");
  chk_vitc_follow: assert property (
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> vitcInsert == ctrlSeen[3])
    else $error("vitc flag wrong");
  chk_nonstd_flag: assert property (
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> nonStandard == |ctrlSeen[8:4])
    else $error("nonstandard flag wrong");
  chk_blank_black: assert property (
    audioMute && $past(audioMute, 2) && outValid && $past(outReady) |->
    pixOut[30:1] == {BLACK_COMP3, BLACK_COMP2, BLACK_COMP1})
    else $error("muted sample not black");
  cov_ctrl_write: cover property (s_axi_bvalid && wrAddr == REG_CTRL);
  cov_mute_rise: cover property ($rose(audioMute));
  cov_out_stall: cover property ((outValid && !outReady) [*3]);
endmodule : sdito_chk

bind sdito_top sdito_chk u_chk (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .outValid, .outReady, .pixOut, .ltcInsert, .vitcInsert,
  .audioMute, .nonStandard);

// *** dv/sdito_sink.sv ***
// Downstream receiver model taking samples from the video output
`timescale 1ns/1ps
module sdito_sink
  import sdito_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Video from the block
  input wire logic outValid,
  output logic outReady,
  input wire sdito_pix_t pixOut,
  // Pace control and capture
  input wire logic stall,
  input wire logic slow,
  output sdito_pix_t lastPix,
  output int takeCnt
);
  logic phase;
  // Ready held off while stalled, every other cycle when slow
  always_ff @(posedge clock) begin
    phase <= rst ? 1'b0 : !phase;
    outReady <= !rst && !stall && (!slow || phase);
  end
  // Capture each accepted sample
  always_ff @(posedge clock) begin
    if (rst) begin
      takeCnt <= 0;
    end else if (outValid && outReady) begin
      lastPix <= pixOut;
      takeCnt <= takeCnt + 1;
    end
  end
endmodule : sdito_sink

// *** dv/tb_top.sv ***
// Self-checking bench for the timecode and output modifier
`timescale 1ns/1ps
module tb_top
  import sdito_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic pixValid = 1'b0, fracRate = 1'b1, generatorMode = 1'b1;
  logic stall = 1'b0, slow = 1'b0, prevMute;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [21:0] referenceClockTime = 22'h0, timecode, refTime, tcKeep;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, outValid, outReady, pixReady, ltcInsert, vitcInsert;
  logic audioMute, nonStandard;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  sdito_pix_t pixIn = '0, pixOut, lastPix, e;
  int takeCnt, t0, n, m, errorCnt = 0, testsRun = 0;
  // Block under test and a copy with the reference fitted
  sdito_top #(.FRAME_RATE(30), .REF_FITTED(1'b0)) u_dut (.clock, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fracRate, .generatorMode,
    .referenceClockTime, .pixValid, .pixReady, .pixIn, .outValid, .outReady,
    .pixOut, .timecode, .ltcInsert, .vitcInsert, .audioMute, .nonStandard);
  sdito_top #(.FRAME_RATE(30), .REF_FITTED(1'b1)) u_ref (.clock, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready, .fracRate, .generatorMode, .referenceClockTime, .pixValid,
    .pixReady(), .pixIn, .outValid(), .outReady(1'b1), .pixOut(),
    .timecode(refTime), .ltcInsert(), .vitcInsert(), .audioMute(),
    .nonStandard());
  sdito_sink u_sink (.clock, .rst, .outValid, .outReady, .pixOut, .stall,
    .slow, .lastPix, .takeCnt);
  always #50 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] tc(input int h, mi, s, f);
    return {10'h0, h[4:0], mi[5:0], s[5:0], f[4:0]};
  endfunction : tc
  task automatic cmp(input string nm, input logic [31:0] ex, sn);
    testsRun++;
    if (sn !== ex) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask : cmp
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    cmp("bresp", r, s_axi_bresp);
    repeat (2) @(posedge clock);
  endtask : axiWr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] ex,
    input logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    cmp("rdata", ex, s_axi_rdata);
    cmp("rresp", r, s_axi_rresp);
  endtask : rdChk
  // Send one sample and wait until the sink has taken it
  task automatic pxSend(input sdito_pix_t p);
    int t;
    t = takeCnt;
    @(posedge clock);
    pixIn <= p;
    pixValid <= 1'b1;
    forever begin
      @(posedge clock);
      if (pixReady) break;
    end
    pixValid <= 1'b0;
    forever begin
      @(posedge clock);
      if (takeCnt != t) break;
    end
    repeat (3) @(posedge clock);
  endtask : pxSend
  task automatic todChk(input logic [31:0] r, o, ex);
    referenceClockTime <= r[21:0];
    axiWr(REG_OFFSET, o, RESP_OKAY);
    cmp("tod", ex, {10'h0, refTime});
  endtask : todChk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rdChk(REG_CTRL, CTRL_RESET, RESP_OKAY);
    rdChk(REG_STATUS, 32'h0000_0018, RESP_OKAY);
    rdChk(8'h20, 32'h0, RESP_SLVERR);
    axiWr(REG_STATUS, 32'h1, RESP_SLVERR);
    axiWr(REG_CTRL, 32'h4, RESP_OKAY);
    cmp("ltc", 1, ltcInsert);
    cmp("vitc", 0, vitcInsert);
    axiWr(REG_CTRL, 32'h8, RESP_OKAY);
    cmp("ltc", 0, ltcInsert);
    cmp("vitc", 1, vitcInsert);
    // Lane 1 only: low control byte must stay as it was
    s_axi_wstrb <= 4'h2;
    axiWr(REG_CTRL, 32'h0F7, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdChk(REG_CTRL, 32'h0000_0008, RESP_OKAY);
    cmp("nonstd", 0, nonStandard);
    // Apply, frame counting and drop frame at minute boundaries
    axiWr(REG_CTRL, 32'h2, RESP_OKAY);
    axiWr(REG_INIT_TIME, tc(0, 0, 59, 29), RESP_OKAY);
    axiWr(REG_APPLY, 32'h1, RESP_OKAY);
    rdChk(REG_TIMECODE, tc(0, 0, 59, 29), RESP_OKAY);
    pxSend({10'h300, 10'h200, 10'h100, 1'b1});
    cmp("tc", tc(0, 1, 0, 2), timecode);
    pxSend({10'h300, 10'h200, 10'h100, 1'b1});
    cmp("tc", tc(0, 1, 0, 3), timecode);
    axiWr(REG_INIT_TIME, tc(0, 9, 59, 29), RESP_OKAY);
    axiWr(REG_APPLY, 32'h1, RESP_OKAY);
    pxSend({10'h300, 10'h200, 10'h100, 1'b1});
    cmp("tc", tc(0, 10, 0, 0), timecode);
    fracRate <= 1'b0;
    axiWr(REG_INIT_TIME, tc(0, 0, 59, 29), RESP_OKAY);
    axiWr(REG_APPLY, 32'h1, RESP_OKAY);
    pxSend({10'h300, 10'h200, 10'h100, 1'b1});
    cmp("tc", tc(0, 1, 0, 0), timecode);
    fracRate <= 1'b1;
    // Each component switched off alone, only as generator
    for (int k = 0; k < 3; k++) begin
      axiWr(REG_CTRL, 32'h80 | (32'h10 << k), RESP_OKAY);
      pxSend({10'h1A0, 10'h150, 10'h100, 1'b1});
      e = {10'h1A0, 10'h150, 10'h100, 1'b1};
      if (k == 0) e.comp1 = BLACK_COMP1;
      if (k == 1) e.comp2 = BLACK_COMP2;
      if (k == 2) e.comp3 = BLACK_COMP3;
      cmp("gate", e, lastPix);
      cmp("nonstd", 1, nonStandard);
    end
    generatorMode <= 1'b0;
    pxSend({10'h1A0, 10'h150, 10'h100, 1'b1});
    cmp("nogen", {10'h1A0, 10'h150, 10'h100, 1'b1}, lastPix);
    generatorMode <= 1'b1;
    // Filter on averages a step, off passes it raw
    axiWr(REG_CTRL, CTRL_RESET, RESP_OKAY);
    pxSend({10'h300, 10'h200, 10'h100, 1'b1});
    pxSend({10'h380, 10'h240, 10'h180, 1'b0});
    cmp("filt", {10'h340, 10'h220, 10'h140, 1'b0}, lastPix);
    axiWr(REG_CTRL, 32'h80, RESP_OKAY);
    pxSend({10'h300, 10'h200, 10'h100, 1'b0});
    cmp("raw", {10'h300, 10'h200, 10'h100, 1'b0}, lastPix);
    // Fill the buffer against a stalled sink, drain slowly
    stall <= 1'b1;
    t0 = takeCnt;
    n = 0;
    @(posedge clock);
    pixIn <= '0;
    pixValid <= 1'b1;
    repeat (30) begin
      @(posedge clock);
      if (pixReady) begin
        n++;
        pixIn <= {20'h0, 10'(n), 1'b0};
      end
    end
    pixValid <= 1'b0;
    // Eight in the buffer plus one in the output stage
    cmp("fill", 9, n);
    slow <= 1'b1;
    stall <= 1'b0;
    repeat (300) begin
      @(posedge clock);
      if (takeCnt == t0 + n) break;
    end
    cmp("drain", n - 1, {22'h0, lastPix.comp1});
    slow <= 1'b0;
    // Picture and sound cycle over 180 ticks, past the wrap into muting
    axiWr(REG_CTRL, 32'h180, RESP_OKAY);
    m = 0;
    prevMute = 1'b0;
    for (int i = 0; i < 180; i++) begin
      pxSend({10'h300, 10'h200, 10'h100, 1'b1});
      e = {BLACK_COMP3, BLACK_COMP2, BLACK_COMP1, 1'b1};
      if (prevMute) cmp("blank", e[30:1], lastPix[30:1]);
      if (audioMute === 1'b1) m++;
      prevMute = audioMute;
      if (i == 100) rdChk(REG_STATUS, 32'h0000_001E, RESP_OKAY);
    end
    cmp("muted", 4 * 30 + 1, m);
    axiWr(REG_CTRL, CTRL_RESET, RESP_OKAY);
    cmp("mute", 0, audioMute);
    // Reference_clock_time_source plus signed offset on the fitted copy only
    tcKeep = timecode;
    axiWr(REG_CTRL, 32'h1, RESP_OKAY);
    todChk(tc(10, 0, 0, 0), 32'h5A, tc(11, 30, 0, 0));
    todChk(tc(10, 0, 0, 0), 32'h8294, tc(23, 0, 0, 0));
    todChk(tc(10, 0, 0, 0), 32'h7D0, tc(9, 59, 0, 0));
    todChk(tc(10, 0, 0, 0), 32'h859F, tc(10, 1, 0, 0));
    todChk(tc(5, 10, 20, 3), 32'h5A, tc(6, 40, 20, 3));
    cmp("prog", tcKeep, timecode);
    summarize();
  end
  // Cut a hang short
  initial begin
    repeat (50000) @(posedge clock);
    errorCnt++;
    summarize();
  end
endmodule : tb_top

// *** rtl/sdito_fifo.sv ***
// FIFO with parameterised width and depth, valid and ready on both sides
`timescale 1ns/1ps
module sdito_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWrite;
  logic doRead;

  // Handshakes on both sides
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  // Storage
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end

endmodule : sdito_fifo

// *** rtl/sdito_pkg.sv ***
// Package: register map, field layouts and timing constants for the block
package sdito_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INIT_TIME = 8'h04;
  localparam logic [7:0] REG_OFFSET = 8'h08;
  localparam logic [7:0] REG_APPLY = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TIMECODE = 8'h14;

  // Control register field positions
  localparam int CTRL_SRC_TOD = 0;
  localparam int CTRL_DROP = 1;
  localparam int CTRL_LTC = 2;
  localparam int CTRL_VITC = 3;
  localparam int CTRL_COMP1_OFF = 4;
  localparam int CTRL_COMP2_OFF = 5;
  localparam int CTRL_COMP3_OFF = 6;
  localparam int CTRL_FILT_OFF = 7;
  localparam int CTRL_AVSYNC = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_01FF;

  // Status register field positions
  localparam int STAT_REF_FITTED = 0;
  localparam int STAT_NONSTD = 1;
  localparam int STAT_AV_ON = 2;
  localparam int STAT_FRAC = 3;
  localparam int STAT_GEN = 4;

  // Offset limit in minutes: 23 hours 59 minutes
  localparam int OFFSET_MAX_MIN = 23 * 60 + 59;
  localparam logic [11:0] MIN_PER_DAY = 12'(24 * 60);

  // Cycle of picture and sound: one second on, four seconds off
  localparam int AV_ON_SEC = 1;
  localparam int AV_OFF_SEC = 4;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timecode value, packed as hh:mm:ss:ff
  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [4:0] frames;
  } sdito_tc_t;

  // Video sample with three components and a frame-start flag
  typedef struct packed {
    logic [9:0] comp3;
    logic [9:0] comp2;
    logic [9:0] comp1;
    logic frameStart;
  } sdito_pix_t;

  // Component black levels
  localparam logic [9:0] BLACK_COMP1 = 10'h040;
  localparam logic [9:0] BLACK_COMP2 = 10'h200;
  localparam logic [9:0] BLACK_COMP3 = 10'h200;

endpackage : sdito_pkg

// *** rtl/sdito_top.sv ***
// Timecode source selection and output modifier for a video generator
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module sdito_top
  import sdito_pkg::*;
#(
  parameter int FRAME_RATE = 30,
  parameter logic REF_FITTED = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Video format and reference_clock_time_source
  input wire logic fracRate,
  input wire logic generatorMode,
  input wire logic [21:0] referenceClockTime,
  // Video in
  input wire logic pixValid,
  output logic pixReady,
  input wire sdito_pix_t pixIn,
  // Video out
  output logic outValid,
  input wire logic outReady,
  output sdito_pix_t pixOut,
  // Timecode and ancillary controls
  output logic [21:0] timecode,
  output logic ltcInsert,
  output logic vitcInsert,
  output logic audioMute,
  output logic nonStandard
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and bus state
  logic [31:0] ctrl;
  sdito_tc_t initTime;
  logic offsetNeg;
  logic [10:0] offsetMin;
  sdito_tc_t progTime;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic applyPulse;
  logic wrBad;

  // Address and data taken in either order
  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (awHeld && wHeld) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (awHeld && wHeld) begin
        wHeld <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;

  // Unmapped write addresses answer with an error
  always_comb begin
    unique case (awAddr)
      REG_CTRL, REG_INIT_TIME, REG_OFFSET, REG_APPLY: wrBad = 1'b0;
      default: wrBad = 1'b1;
    endcase
  end

  // Write response
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (awHeld && wHeld) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrBad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes, byte lane 0 and 1 for control
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      initTime <= '0;
      offsetNeg <= 1'b0;
      offsetMin <= 11'h000;
      applyPulse <= 1'b0;
    end else begin
      applyPulse <= 1'b0;
      if (awHeld && wHeld) begin
        unique case (awAddr)
          REG_CTRL: begin
            if (wStrb[0]) ctrl[7:0] <= wData[7:0];
            if (wStrb[1]) ctrl[8] <= wData[8];
          end
          REG_INIT_TIME: begin
            if (&wStrb[2:0]) initTime <= wData[21:0];
          end
          REG_OFFSET: begin
            // Offset clamped to 23:59
            if (&wStrb[1:0]) begin
              offsetNeg <= wData[15];
              offsetMin <= (wData[10:0] > 11'(OFFSET_MAX_MIN))
                ? 11'(OFFSET_MAX_MIN) : wData[10:0];
            end
          end
          REG_APPLY: applyPulse <= wData[0] && wStrb[0] && !REF_FITTED;
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] readMux;
  logic rdBad;
  logic avBlank;

  // Read data multiplexer
  always_comb begin
    readMux = 32'h0000_0000;
    rdBad = 1'b0;
    unique case (s_axi_araddr)
      REG_CTRL: readMux = ctrl & CTRL_MASK;
      REG_INIT_TIME: readMux = {10'h000, initTime};
      REG_OFFSET: readMux = {16'h0000, offsetNeg, 4'h0, offsetMin};
      REG_APPLY: readMux = 32'h0000_0000;
      REG_STATUS: readMux = {27'h0, generatorMode, fracRate, avBlank,
                             nonStandard, REF_FITTED};
      REG_TIMECODE: readMux = {10'h000, timecode};
      default: rdBad = 1'b1;
    endcase
  end

  // Read answer one cycle after address
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readMux;
      s_axi_rresp <= rdBad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  //////////////////////////////////////////////////////////////////////////
  // Program time counter
  logic frameTick;
  logic dropOn;
  logic [4:0] lastFrame;
  sdito_tc_t next_progTime;

  assign dropOn = ctrl[CTRL_DROP] && fracRate;
  assign lastFrame = 5'(FRAME_RATE - 1);

  // Next frame count with drop-frame skipping
  always_comb begin
    next_progTime = progTime;
    if (progTime.frames != lastFrame) begin
      next_progTime.frames = progTime.frames + 5'h01;
    end else begin
      next_progTime.frames = 5'h00;
      if (progTime.seconds != 6'h3B) begin
        next_progTime.seconds = progTime.seconds + 6'h01;
      end else begin
        next_progTime.seconds = 6'h00;
        if (progTime.minutes != 6'h3B) begin
          next_progTime.minutes = progTime.minutes + 6'h01;
        end else begin
          next_progTime.minutes = 6'h00;
          next_progTime.hours = (progTime.hours == 5'h17)
            ? 5'h00 : progTime.hours + 5'h01;
        end
        // Frames 0 and 1 skipped except every tenth minute
        if (dropOn && (6'(next_progTime.minutes % 6'd10) != 6'h00)) begin
          next_progTime.frames = 5'h02;
        end
      end
    end
  end

  // Counter advance or load
  always_ff @(posedge clock) begin
    if (rst) begin
      progTime <= '0;
    end else if (applyPulse) begin
      progTime <= initTime;
    end else if (frameTick) begin
      progTime <= next_progTime;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference_clock_time_source plus offset, wrapping over 24 hours
  sdito_tc_t todIn;
  logic [11:0] todMin;
  logic [11:0] sumMin;
  sdito_tc_t todAdj;

  // Local time taken as given
  assign todIn = referenceClockTime;

  always_comb begin
    todMin = 12'(todIn.hours) * 12'd60 + 12'(todIn.minutes);
    if (offsetNeg) begin
      sumMin = (todMin >= 12'(offsetMin))
        ? todMin - 12'(offsetMin) : todMin + MIN_PER_DAY - 12'(offsetMin);
    end else begin
      sumMin = todMin + 12'(offsetMin);
      if (sumMin >= MIN_PER_DAY) sumMin = sumMin - MIN_PER_DAY;
    end
    todAdj = todIn;
    todAdj.hours = 5'(sumMin / 12'd60);
    todAdj.minutes = 6'(sumMin % 12'd60);
  end

  // Source choice, reference_clock_time_source only with reference fitted
  always_ff @(posedge clock) begin
    if (rst) begin
      timecode <= '0;
    end else if (ctrl[CTRL_SRC_TOD] && REF_FITTED) begin
      timecode <= todAdj;
    end else begin
      timecode <= progTime;
    end
  end

  // Ancillary timecode insertion enables
  always_ff @(posedge clock) begin
    if (rst) begin
      ltcInsert <= 1'b0;
      vitcInsert <= 1'b0;
    end else begin
      ltcInsert <= ctrl[CTRL_LTC];
      vitcInsert <= ctrl[CTRL_VITC];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Picture-sound cycle by frame count
  logic [8:0] avCount;

  always_ff @(posedge clock) begin
    if (rst || !ctrl[CTRL_AVSYNC]) begin
      avCount <= 9'h000;
    end else if (frameTick) begin
      avCount <= (avCount == 9'((AV_ON_SEC + AV_OFF_SEC) * FRAME_RATE - 1))
        ? 9'h000 : avCount + 9'h001;
    end
  end

  // Blank after the first second of each cycle
  assign avBlank = ctrl[CTRL_AVSYNC]
    && (avCount >= 9'(AV_ON_SEC * FRAME_RATE));

  // Non-standard flag and mute
  always_ff @(posedge clock) begin
    if (rst) begin
      nonStandard <= 1'b0;
      audioMute <= 1'b0;
    end else begin
      nonStandard <= |ctrl[CTRL_AVSYNC:CTRL_COMP1_OFF];
      audioMute <= avBlank;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Video path: input FIFO, gating, edge filter
  sdito_pix_t fifoPix;
  logic fifoValid;
  logic take;
  sdito_pix_t prevPix;
  sdito_pix_t gated;
  sdito_pix_t filt;

  sdito_fifo #(.WIDTH($bits(sdito_pix_t)), .DEPTH(8)) uFifo (
    .clock(clock),
    .rst(rst),
    .inValid(pixValid),
    .inReady(pixReady),
    .inData(pixIn),
    .outValid(fifoValid),
    .outReady(take),
    .outData(fifoPix)
  );

  // Output register drains FIFO when empty or taken
  assign take = fifoValid && (!outValid || outReady);
  assign frameTick = take && fifoPix.frameStart;

  // Gating and black substitution
  always_comb begin
    gated = fifoPix;
    if (generatorMode) begin
      if (ctrl[CTRL_COMP1_OFF]) gated.comp1 = BLACK_COMP1;
      if (ctrl[CTRL_COMP2_OFF]) gated.comp2 = BLACK_COMP2;
      if (ctrl[CTRL_COMP3_OFF]) gated.comp3 = BLACK_COMP3;
    end
    if (avBlank) begin
      gated.comp1 = BLACK_COMP1;
      gated.comp2 = BLACK_COMP2;
      gated.comp3 = BLACK_COMP3;
    end
    // Two-tap averaging softens edges; disabled passes levels instantly
    filt = gated;
    if (!ctrl[CTRL_FILT_OFF] && !gated.frameStart) begin
      filt.comp1 = 10'((11'(gated.comp1) + 11'(prevPix.comp1)) >> 1);
      filt.comp2 = 10'((11'(gated.comp2) + 11'(prevPix.comp2)) >> 1);
      filt.comp3 = 10'((11'(gated.comp3) + 11'(prevPix.comp3)) >> 1);
    end
  end

  // Output stage
  always_ff @(posedge clock) begin
    if (rst) begin
      outValid <= 1'b0;
      pixOut <= '0;
      prevPix <= '0;
    end else if (take) begin
      outValid <= 1'b1;
      pixOut <= filt;
      prevPix <= gated;
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule : sdito_top
